// [verilog/celb_pkg.sv]
`default_nettype none
package celb_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned BUS_W  = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SYNC_W = 13;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_OE    = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_BIST  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RXPWR = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_PINS  = 8'h10;

  // ---------------------------------------------------------------
  // control register fields and reset value
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_SOFT_RST_BIT = 0;
  localparam int unsigned CTRL_OE_OPEN_BIT  = 1;
  localparam int unsigned CTRL_BIST_OPEN_BIT = 2;
  localparam int unsigned CTRL_RX_OPEN_BIT  = 3;
  localparam int unsigned CTRL_W            = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST    = 4'h E;

  // ---------------------------------------------------------------
  // pin status field positions
  // ---------------------------------------------------------------
  localparam int unsigned PINS_BUS_LSB  = 0;
  localparam int unsigned PINS_OE_LE    = 8;
  localparam int unsigned PINS_BIST_LE  = 9;
  localparam int unsigned PINS_RX_LE    = 10;
  localparam int unsigned PINS_RESET_N  = 11;
  localparam int unsigned PINS_REF_TIMING_CLOCK   = 12;

  // ---------------------------------------------------------------
  // latch disabled values
  // ---------------------------------------------------------------
  localparam logic [BUS_W-1:0] OE_RST   = 8'h00;
  localparam logic [BUS_W-1:0] BIST_RST = 8'hFF;
  localparam logic [BUS_W-1:0] RX_RST   = 8'h00;

  // bit-to-channel map: entry i names the bus bit that feeds channel i
  typedef logic [2:0] celb_idx_t;
  typedef celb_idx_t [BUS_W-1:0] celb_map_t;
  localparam celb_map_t MAP_IDENT = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

  typedef struct packed {
    logic [BUS_W-1:0] oe;
    logic [BUS_W-1:0] bist;
    logic [BUS_W-1:0] rx;
  } celb_latch_s;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } celb_bus_req_s;

endpackage
`default_nettype wire

// [verilog/celb_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module celb_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] async_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] sync_o
);

  // reset value input is unused; every flop resets to zero
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  for (genvar g = 0; g < W; g++) begin : g_bit
    if (g < 0) begin : g_never
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_o <= sync_nxt;
    end
  end

endmodule
`default_nettype wire

// [verilog/celb_latch_bank.sv]
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1: output latch open passes bus to drivers
// R2: enable bit high drives, low powers down
// R3: output latch falling edge holds bus value
// R4: sampled reset clears all driver enables
// R5: self-test latch open passes bus through
// R6: low self-test bit runs pattern generate/compare
// R7: high self-test bit keeps normal traffic
// R8: self-test latch falling edge holds bus
// R9: reset with latch closed disables self-test
// R10: receive-power latch open passes bus through
// R11: high bit powers receiver, low powers down
// R12: receive-power latch falling edge holds bus
// R13: reset clears all receive power enables
// R14: reset acts when low at reference rising edge
// R15: bit-to-channel mapping is fixed parameter table
module celb_latch_bank #(
  parameter celb_pkg::celb_map_t OE_MAP   = celb_pkg::MAP_IDENT,
  parameter celb_pkg::celb_map_t BIST_MAP = celb_pkg::MAP_IDENT,
  parameter celb_pkg::celb_map_t RX_MAP   = celb_pkg::MAP_IDENT
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rstn_i,
  input  wire logic [celb_pkg::BUS_W-1:0]    shared_enable_bus_i,
  input  wire logic                          serial_out_latch_enable_i,
  input  wire logic                          selftest_latch_enable_i,
  input  wire logic                          rx_power_latch_enable_i,
  input  wire logic                          device_reset_n_i,
  input  wire logic                          ref_timing_clock_i,
  input  wire logic [celb_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [celb_pkg::DATA_W-1:0]   reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output logic      [celb_pkg::DATA_W-1:0]   reg_rdata_o,
  output logic      [celb_pkg::BUS_W-1:0]    serial_out_pair_en_o,
  output logic      [celb_pkg::BUS_W-1:0]    selftest_run_o,
  output logic      [celb_pkg::BUS_W-1:0]    rx_power_en_o
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [celb_pkg::SYNC_W-1:0] pins_raw;
  logic [celb_pkg::SYNC_W-1:0] pins_sync;
  logic [celb_pkg::BUS_W-1:0]  bus_s;
  logic                        oe_le_s;
  logic                        bist_le_s;
  logic                        rx_le_s;
  logic                        dev_rst_n_s;
  logic                        ref_s;

  assign pins_raw = {ref_timing_clock_i, device_reset_n_i, rx_power_latch_enable_i,
                     selftest_latch_enable_i, serial_out_latch_enable_i,
                     shared_enable_bus_i};

  celb_sync #(
    .W (celb_pkg::SYNC_W)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .async_i   (pins_raw),
    .rst_val_i ('0),
    .sync_o    (pins_sync)
  );

  assign bus_s       = pins_sync[celb_pkg::PINS_BUS_LSB +: celb_pkg::BUS_W];
  assign oe_le_s     = pins_sync[celb_pkg::PINS_OE_LE];
  assign bist_le_s   = pins_sync[celb_pkg::PINS_BIST_LE];
  assign rx_le_s     = pins_sync[celb_pkg::PINS_RX_LE];
  assign dev_rst_n_s = pins_sync[celb_pkg::PINS_RESET_N];
  assign ref_s       = pins_sync[celb_pkg::PINS_REF_TIMING_CLOCK];

  // ---------------------------------------------------------------
  // reference-edge reset sampling
  // ---------------------------------------------------------------
  logic ref_d_r;
  logic ref_d_nxt;
  logic dev_rst_hit;

  always_comb begin
    ref_d_nxt = ref_s;
  end

  // reset counts only when seen low at a rising reference edge
  assign dev_rst_hit = ref_s && !ref_d_r && !dev_rst_n_s; // [R14]

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_d_r <= 1'b0;
    end else begin
      ref_d_r <= ref_d_nxt;
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic [celb_pkg::CTRL_W-1:0] ctrl_r;
  logic [celb_pkg::CTRL_W-1:0] ctrl_nxt;
  logic                        soft_rst;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (reg_wr_i && reg_addr_i == celb_pkg::ADDR_CTRL) begin
      ctrl_nxt = reg_wdata_i[celb_pkg::CTRL_W-1:0];
    end else begin
      // soft reset is self clearing
      ctrl_nxt[celb_pkg::CTRL_SOFT_RST_BIT] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= celb_pkg::CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign soft_rst = ctrl_r[celb_pkg::CTRL_SOFT_RST_BIT];

  // ---------------------------------------------------------------
  // latches (reset loads the disabled values, except into an open bist latch; else transparent while enable high and the control open bit set, hold otherwise)
  // ---------------------------------------------------------------
  celb_pkg::celb_latch_s lat_r;
  celb_pkg::celb_latch_s lat_nxt;
  logic                  oe_open;
  logic                  bist_open;
  logic                  rx_open;
  logic                  any_rst;

  assign oe_open   = oe_le_s && ctrl_r[celb_pkg::CTRL_OE_OPEN_BIT];
  assign bist_open = bist_le_s && ctrl_r[celb_pkg::CTRL_BIST_OPEN_BIT];
  assign rx_open   = rx_le_s && ctrl_r[celb_pkg::CTRL_RX_OPEN_BIT];
  assign any_rst   = dev_rst_hit || soft_rst;

  always_comb begin
    lat_nxt = lat_r;
    // closing keeps the last transparent value, since the latch holds it
    if (any_rst) begin
      lat_nxt.oe = celb_pkg::OE_RST; // [R4]
    end else if (oe_open) begin
      lat_nxt.oe = bus_s; // [R1] [R3]
    end
    // an open self-test latch keeps following the bus through reset
    if (bist_open) begin
      lat_nxt.bist = bus_s; // [R5] [R8]
    end else if (any_rst) begin
      lat_nxt.bist = celb_pkg::BIST_RST; // [R9]
    end
    if (any_rst) begin
      lat_nxt.rx = celb_pkg::RX_RST; // [R13]
    end else if (rx_open) begin
      lat_nxt.rx = bus_s; // [R10] [R12]
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lat_r <= '{oe: celb_pkg::OE_RST, bist: celb_pkg::BIST_RST, rx: celb_pkg::RX_RST};
    end else begin
      lat_r <= lat_nxt;
    end
  end

  // ---------------------------------------------------------------
  // channel mapping and outputs
  // ---------------------------------------------------------------
  logic [celb_pkg::BUS_W-1:0] oe_map_nxt;
  logic [celb_pkg::BUS_W-1:0] bist_map_nxt;
  logic [celb_pkg::BUS_W-1:0] rx_map_nxt;

  for (genvar g = 0; g < celb_pkg::BUS_W; g++) begin : g_map
    assign oe_map_nxt[g]   = lat_nxt.oe[OE_MAP[g]]; // [R15] [R2]
    assign bist_map_nxt[g] = !lat_nxt.bist[BIST_MAP[g]]; // [R15] [R6] [R7]
    assign rx_map_nxt[g]   = lat_nxt.rx[RX_MAP[g]]; // [R15] [R11]
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_out_pair_en_o <= '0;
      selftest_run_o       <= '0;
      rx_power_en_o        <= '0;
    end else begin
      serial_out_pair_en_o <= oe_map_nxt;
      selftest_run_o       <= bist_map_nxt;
      rx_power_en_o        <= rx_map_nxt;
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  logic [celb_pkg::DATA_W-1:0] rdata_nxt;

  always_comb begin
    rdata_nxt = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        celb_pkg::ADDR_CTRL: begin
          rdata_nxt[celb_pkg::CTRL_W-1:0] = ctrl_r;
        end
        celb_pkg::ADDR_OE: begin
          rdata_nxt[celb_pkg::BUS_W-1:0] = lat_r.oe;
        end
        celb_pkg::ADDR_BIST: begin
          rdata_nxt[celb_pkg::BUS_W-1:0] = lat_r.bist;
        end
        celb_pkg::ADDR_RXPWR: begin
          rdata_nxt[celb_pkg::BUS_W-1:0] = lat_r.rx;
        end
        celb_pkg::ADDR_PINS: begin
          rdata_nxt[celb_pkg::SYNC_W-1:0] = pins_sync;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

// [test/celb_latch_bank_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module celb_latch_bank_asserts #(
  parameter celb_pkg::celb_map_t OE_MAP   = celb_pkg::MAP_IDENT,
  parameter celb_pkg::celb_map_t BIST_MAP = celb_pkg::MAP_IDENT,
  parameter celb_pkg::celb_map_t RX_MAP   = celb_pkg::MAP_IDENT
) (
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  shared_enable_bus_i,
  input wire logic        serial_out_latch_enable_i,
  input wire logic        selftest_latch_enable_i,
  input wire logic        rx_power_latch_enable_i,
  input wire logic        device_reset_n_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [7:0]  serial_out_pair_en_o,
  input wire logic [7:0]  selftest_run_o,
  input wire logic [7:0]  rx_power_en_o
);
  // ---------------------------------------------------------------
  // open-allow copy of the control register
  // ---------------------------------------------------------------
  logic [2:0] ok_r;
  logic [2:0] ok_nxt;
  logic       q;
  logic       st;
  assign q = device_reset_n_i && !reg_wr_i;
  always_comb begin
    ok_nxt = ok_r;
    if (reg_wr_i && reg_addr_i == celb_pkg::ADDR_CTRL) begin
      ok_nxt = reg_wdata_i[3:1];
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ok_r <= 3'h7;
    end else begin
      ok_r <= ok_nxt;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    st <= (shared_enable_bus_i == $past(shared_enable_bus_i));
  end
  // bus routed through the instance's channel map
  logic [7:0] oe_exp;
  logic [7:0] bist_exp;
  logic [7:0] rx_exp;
  for (genvar g = 0; g < 8; g++) begin : g_exp
    assign oe_exp[g]   = shared_enable_bus_i[OE_MAP[g]];
    assign bist_exp[g] = !shared_enable_bus_i[BIST_MAP[g]];
    assign rx_exp[g]   = shared_enable_bus_i[RX_MAP[g]];
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_oe_follow: assert property (
    (serial_out_latch_enable_i && ok_r[0] && q && st)[*8]
    |-> serial_out_pair_en_o == oe_exp) else $error("oe not following");
  a_bist_follow: assert property (
    (selftest_latch_enable_i && ok_r[1] && !reg_wr_i && st)[*8]
    |-> selftest_run_o == bist_exp) else $error("selftest not following");
  a_rx_follow: assert property (
    (rx_power_latch_enable_i && ok_r[2] && q && st)[*8]
    |-> rx_power_en_o == rx_exp) else $error("rx not following");
  a_oe_hold: assert property (
    (!serial_out_latch_enable_i && q)[*6] |-> $stable(serial_out_pair_en_o))
    else $error("oe not held");
  a_bist_hold: assert property (
    (!selftest_latch_enable_i && q)[*6] |-> $stable(selftest_run_o))
    else $error("selftest not held");
  a_rx_hold: assert property (
    (!rx_power_latch_enable_i && q)[*6] |-> $stable(rx_power_en_o))
    else $error("rx not held");
  a_dev_clear: assert property (
    (!device_reset_n_i && !serial_out_latch_enable_i && !rx_power_latch_enable_i)[*8] ##1
    (!device_reset_n_i && !serial_out_latch_enable_i && !rx_power_latch_enable_i)[*4]
    |-> serial_out_pair_en_o == 8'h00 && rx_power_en_o == 8'h00) else $error("no clear");
  a_bist_clear: assert property (
    (!device_reset_n_i && !selftest_latch_enable_i)[*8] ##1
    (!device_reset_n_i && !selftest_latch_enable_i)[*4] |-> selftest_run_o == 8'h00)
    else $error("selftest not cleared");
  a_rdata_idle: assert property (
    !$past(reg_rd_i) || $past(reg_addr_i) == 8'h14 |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data not zero");
  c_oe_close: cover property (serial_out_latch_enable_i ##1 !serial_out_latch_enable_i);
  c_dev_rst: cover property (!device_reset_n_i [*8]);
  c_read: cover property (reg_rd_i);
endmodule
bind celb_latch_bank celb_latch_bank_asserts #(
  .OE_MAP   (OE_MAP),
  .BIST_MAP (BIST_MAP),
  .RX_MAP   (RX_MAP)
) u_chk (.sys_clk_i, .rstn_i,
  .shared_enable_bus_i, .serial_out_latch_enable_i, .selftest_latch_enable_i,
  .rx_power_latch_enable_i, .device_reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .serial_out_pair_en_o, .selftest_run_o, .rx_power_en_o);
`default_nettype wire

// [test/celb_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module celb_host_model (
  input  wire logic       sys_clk_i,
  output logic            ref_o,
  output logic            rst_n_o,
  output logic      [7:0] bus_o,
  output logic      [2:0] le_o
);
  int unsigned div_r;
  initial begin
    ref_o = 1'b0;
    rst_n_o = 1'b1;
    bus_o = 8'h00;
    le_o = 3'h0;
    div_r = 0;
  end
  // free running reference, three system cycles per phase
  always @(posedge sys_clk_i) begin
    div_r <= (div_r == 2) ? 0 : div_r + 1;
    if (div_r == 2) begin
      ref_o <= ~ref_o;
    end
  end
  task automatic open_le(input int sel, input logic [7:0] val);
    bus_o <= val;
    repeat (2) @(posedge sys_clk_i);
    le_o[sel] <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
  endtask
  task automatic close_le(input int sel);
    le_o[sel] <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    // bus moves on so a transparent latch is caught
    bus_o <= ~bus_o;
    repeat (6) @(posedge sys_clk_i);
  endtask
  task automatic dev_reset();
    rst_n_o <= 1'b0;
    repeat (14) @(posedge sys_clk_i);
    rst_n_o <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
  endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk;
  logic        rstn;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [31:0] wd;
  logic [31:0] rdat;
  logic [7:0]  oe;
  logic [7:0]  run;
  logic [7:0]  rx;
  logic        refc;
  logic        dr_n;
  logic [7:0]  bus;
  logic [2:0]  le;
  logic [7:0]  oe_m;
  logic [7:0]  run_m;
  logic [7:0]  rx_m;
  // second instance with every channel fed by the mirrored bus bit
  localparam celb_pkg::celb_map_t MAP_REV = {3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  int          error_cnt = 0;
  int          compares = 0;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  celb_host_model u_host (.sys_clk_i(clk), .ref_o(refc), .rst_n_o(dr_n), .bus_o(bus),
    .le_o(le));
  celb_latch_bank u_dut (.sys_clk_i(clk), .rstn_i(rstn), .shared_enable_bus_i(bus),
    .serial_out_latch_enable_i(le[0]), .selftest_latch_enable_i(le[1]),
    .rx_power_latch_enable_i(le[2]), .device_reset_n_i(dr_n), .ref_timing_clock_i(refc),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
    .serial_out_pair_en_o(oe), .selftest_run_o(run), .rx_power_en_o(rx));
  celb_latch_bank #(.OE_MAP(MAP_REV), .BIST_MAP(MAP_REV), .RX_MAP(MAP_REV)) u_dut_map (
    .sys_clk_i(clk), .rstn_i(rstn), .shared_enable_bus_i(bus),
    .serial_out_latch_enable_i(le[0]), .selftest_latch_enable_i(le[1]),
    .rx_power_latch_enable_i(le[2]), .device_reset_n_i(dr_n), .ref_timing_clock_i(refc),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(),
    .serial_out_pair_en_o(oe_m), .selftest_run_o(run_m), .rx_power_en_o(rx_m));
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(what, rdat, exp);
    @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic outs(input logic [7:0] e_oe, input logic [7:0] e_run, input logic [7:0] e_rx);
    @(negedge clk);
    check("oe", {24'h0, oe}, {24'h0, e_oe});
    check("run", {24'h0, run}, {24'h0, e_run});
    check("rx", {24'h0, rx}, {24'h0, e_rx});
    check("oe map", {24'h0, oe_m}, {24'h0, rev8(e_oe)});
    check("run map", {24'h0, run_m}, {24'h0, rev8(e_run)});
    check("rx map", {24'h0, rx_m}, {24'h0, rev8(e_rx)});
    @(posedge clk);
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wd = 32'h0000_0000;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk("ctrl", celb_pkg::ADDR_CTRL, 32'h0000_000E);
    rd_chk("bist", celb_pkg::ADDR_BIST, 32'h0000_00FF);
    rd_chk("hole", 8'h14, 32'h0000_0000);
    u_host.open_le(0, 8'hA6);
    u_host.close_le(0);
    u_host.open_le(1, 8'h3C);
    u_host.close_le(1);
    u_host.open_le(2, 8'h5C);
    u_host.close_le(2);
    outs(8'hA6, 8'hC3, 8'h5C);
    rd_chk("oe reg", celb_pkg::ADDR_OE, 32'h0000_00A6);
    rd_chk("rx reg", celb_pkg::ADDR_RXPWR, 32'h0000_005C);
    // output latch barred from opening
    wr_reg(celb_pkg::ADDR_CTRL, 32'h0000_000C);
    u_host.open_le(0, 8'hFF);
    u_host.close_le(0);
    outs(8'hA6, 8'hC3, 8'h5C);
    wr_reg(celb_pkg::ADDR_CTRL, 32'h0000_000E);
    u_host.dev_reset();
    outs(8'h00, 8'h00, 8'h00);
    // open self-test latch is not forced by reset
    u_host.open_le(1, 8'h0F);
    u_host.dev_reset();
    outs(8'h00, 8'hF0, 8'h00);
    u_host.close_le(1);
    u_host.open_le(0, 8'h81);
    u_host.close_le(0);
    wr_reg(celb_pkg::ADDR_CTRL, 32'h0000_000F);
    repeat (3) @(posedge clk);
    outs(8'h00, 8'h00, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
